// *** ack_enable_bit_pkg.sv ***
/*
 * Shared constants for the two-wire error and arbitration block:
 * status codes, byte framing positions and reset values.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package ack_enable_bit_pkg;

	// ==================================================================
	// status codes
	localparam logic [7:0] ST_NO_INFO      = 8'hf8;
	localparam logic [7:0] ST_BUS_ERROR    = 8'h00;
	localparam logic [7:0] ST_ARB_ADDR_RD  = 8'hb0;
	localparam logic [7:0] ST_ARB_ADDR_WR  = 8'h68;
	localparam logic [7:0] ST_ARB_LOST     = 8'h38;

	// ==================================================================
	// framing
	localparam int         ADDR_W          = 7;
	localparam logic [3:0] BIT_RW          = 4'h7;
	localparam logic [3:0] BIT_ACK         = 4'h8;
	localparam logic [3:0] BIT_FIRST       = 4'h0;

	// ==================================================================
	// reset values
	localparam logic       PIN_IDLE        = 1'b1;
	localparam logic       CTRL_RST        = 1'b0;

	typedef enum logic [2:0] {
		ACK_ENABLE_BIT_NAS,
		ACK_ENABLE_BIT_MASTER,
		ACK_ENABLE_BIT_SLV_CHECK,
		ACK_ENABLE_BIT_SLV_RX,
		ACK_ENABLE_BIT_SLV_TX,
		ACK_ENABLE_BIT_WAIT_FREE,
		ACK_ENABLE_BIT_BUS_ERR
	} ack_enable_bit_state_t;

endpackage : ack_enable_bit_pkg

// *** ack_enable_bit_sync.sv ***
/*
 * Two-flop synchroniser for pin inputs, with clock enable.
 * Assumes inputs are asynchronous to clock_i; only q_o may be read.
 */
`timescale 1ns/1ps
module ack_enable_bit_sync
	import ack_enable_bit_pkg::*;
#(
	parameter int         WIDTH    = 2,
	parameter logic [1:0] RST_VAL  = 2'h3
) (
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic             clk_en_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta;

	generate
		if (WIDTH < 1 || WIDTH > 2) begin : g_bad_width
			$error("ack_enable_bit_sync: WIDTH must be 1 or 2");
		end
	endgenerate

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= RST_VAL[WIDTH-1:0];
			q_o  <= RST_VAL[WIDTH-1:0];
		end else if (clk_en_i) begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule : ack_enable_bit_sync

// *** ack_enable_bit_core.sv ***
/*
 * Two-wire bus error detection, repeated start tracking and multi-master
 * arbitration with the mode changes that follow a loss.
 * Assumes a separate byte engine drives master bits and SCL pulls, and that
 * software control writes arrive as one-cycle strobes on clock_i.
 */
`timescale 1ns/1ps
module ack_enable_bit_core
	import ack_enable_bit_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	input  wire logic          clock_i,
	input  wire logic          rst_n_i,
	input  wire logic          clk_en_i,
	input  wire logic          scl_i,
	input  wire logic          sda_i,
	output logic               scl_oe_o,
	output logic               sda_oe_o,
	input  wire logic          ctrl_write_i,
	input  wire logic          ctrl_start_i,
	input  wire logic          ctrl_stop_i,
	input  wire logic          ctrl_done_clr_i,
	input  wire logic          ctrl_ack_en_i,
	input  wire logic [AW-1:0] own_addr_i,
	input  wire logic          master_own_i,
	input  wire logic          master_tx_en_i,
	input  wire logic          master_tx_bit_i,
	input  wire logic          master_scl_low_i,
	output logic               start_request_bit_o,
	output logic               stop_request_bit_o,
	output logic               ack_enable_bit_o,
	output logic               transfer_done_flag_o,
	output logic [7:0]         bus_status_o,
	output logic [2:0]         mode_o,
	output logic               bus_busy_o,
	output logic               start_when_free_o
);

	generate
		if (AW != ADDR_W) begin : g_bad_aw
			$error("ack_enable_bit_core: AW must equal the address width");
		end
	endgenerate

	// ==================================================================
	// pin sampling and condition detection
	logic [1:0]  pins_s;
	logic        scl_q;
	logic        sda_q;
	ack_enable_bit_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_sync (
		.clock_i  (clock_i),
		.rst_n_i  (rst_n_i),
		.clk_en_i (clk_en_i),
		.d_i      ({scl_i, sda_i}),
		.q_o      (pins_s)
	);

	wire scl_s     = pins_s[1];
	wire sda_s     = pins_s[0];
	wire scl_rise  = scl_s & ~scl_q;
	wire scl_fall  = ~scl_s & scl_q;
	wire start_det = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;

	// ==================================================================
	// state
	ack_enable_bit_state_t     state;
	ack_enable_bit_state_t     next_state;
	logic [3:0]      bit_cnt;
	logic            skip_fall;
	logic            in_frame;
	logic            first_byte;
	logic [AW-1:0]   shift;
	logic            done;
	logic [7:0]      status_code;
	logic            start_bit;
	logic            stop_bit;
	logic            ack_bit;

	// boundary between bytes is the only legal place for start or stop
	wire at_boundary = (bit_cnt == BIT_FIRST);
	wire illegal_cond = in_frame & ~at_boundary & (start_det | stop_det);
	wire recover_wr = ctrl_write_i & ctrl_stop_i & ctrl_done_clr_i
	                  & (state == ACK_ENABLE_BIT_BUS_ERR);
	// equal bits never trip this, so identical masters carry on
	wire arb_lost = (state == ACK_ENABLE_BIT_MASTER) & master_tx_en_i & master_tx_bit_i
	                & scl_rise & ~sda_s & (bit_cnt != BIT_ACK);
	wire lost_in_addr = first_byte & (bit_cnt < BIT_RW);
	wire addr_done = (state == ACK_ENABLE_BIT_SLV_CHECK) & scl_rise & (bit_cnt == BIT_RW);
	wire addr_match = ack_bit & (shift == own_addr_i);
	wire lost_exit_wait = start_bit;
	// a loss inside the address is reported only if the address check then finds a match
	wire ev_set = illegal_cond | (arb_lost & ~lost_in_addr) | (addr_done & addr_match);

	always_comb begin
		next_state = state;
		case (state)
			ACK_ENABLE_BIT_NAS: begin
				if (master_own_i) begin
					next_state = ACK_ENABLE_BIT_MASTER;
				end
			end
			ACK_ENABLE_BIT_MASTER: begin
				if (arb_lost) begin
					if (lost_in_addr) begin
						next_state = ACK_ENABLE_BIT_SLV_CHECK;
					end else if (lost_exit_wait) begin
						next_state = ACK_ENABLE_BIT_WAIT_FREE;
					end else begin
						next_state = ACK_ENABLE_BIT_NAS;
					end
				end else if (stop_det | ~master_own_i) begin
					next_state = ACK_ENABLE_BIT_NAS;
				end
			end
			ACK_ENABLE_BIT_SLV_CHECK: begin
				if (addr_done) begin
					if (addr_match) begin
						next_state = sda_s ? ACK_ENABLE_BIT_SLV_TX : ACK_ENABLE_BIT_SLV_RX;
					end else if (lost_exit_wait) begin
						next_state = ACK_ENABLE_BIT_WAIT_FREE;
					end else begin
						next_state = ACK_ENABLE_BIT_NAS;
					end
				end
			end
			ACK_ENABLE_BIT_SLV_RX, ACK_ENABLE_BIT_SLV_TX: begin
				if (stop_det | start_det) begin
					next_state = ACK_ENABLE_BIT_NAS;
				end
			end
			ACK_ENABLE_BIT_WAIT_FREE: begin
				if (~bus_busy_o) begin
					next_state = ACK_ENABLE_BIT_NAS;
				end
			end
			ACK_ENABLE_BIT_BUS_ERR: begin
				if (recover_wr) begin
					next_state = ACK_ENABLE_BIT_NAS;
				end
			end
			default: next_state = ACK_ENABLE_BIT_NAS;
		endcase
		if (illegal_cond) begin
			next_state = ACK_ENABLE_BIT_BUS_ERR;
		end
	end

	// ==================================================================
	// framing tracker: counts falling edges, bit 8 is the acknowledge
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_q      <= PIN_IDLE;
			sda_q      <= PIN_IDLE;
			bit_cnt    <= BIT_FIRST;
			skip_fall  <= 1'b0;
			in_frame   <= 1'b0;
			first_byte <= 1'b0;
			shift      <= '0;
			bus_busy_o <= 1'b0;
		end else if (clk_en_i) begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			if (scl_rise) begin
				shift <= {shift[AW-2:0], sda_s};
			end
			if (start_det) begin
				bit_cnt    <= BIT_FIRST;
				skip_fall  <= 1'b1;
				in_frame   <= 1'b1;
				first_byte <= 1'b1;
				bus_busy_o <= 1'b1;
			end else if (stop_det) begin
				bit_cnt    <= BIT_FIRST;
				in_frame   <= 1'b0;
				bus_busy_o <= 1'b0;
			end else if (recover_wr) begin
				bit_cnt  <= BIT_FIRST;
				in_frame <= 1'b0;
			end else if (scl_fall) begin
				skip_fall <= 1'b0;
				if (!skip_fall) begin
					if (bit_cnt == BIT_ACK) begin
						bit_cnt    <= BIT_FIRST;
						first_byte <= 1'b0;
					end else begin
						bit_cnt <= bit_cnt + 4'h1;
					end
				end
			end
		end
	end

	// ==================================================================
	// control bits, done flag and status
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state       <= ACK_ENABLE_BIT_NAS;
			done        <= 1'b0;
			status_code <= ST_NO_INFO;
			start_bit   <= CTRL_RST;
			stop_bit    <= CTRL_RST;
			ack_bit     <= CTRL_RST;
		end else if (clk_en_i) begin
			state <= next_state;
			if (ctrl_write_i) begin
				start_bit <= ctrl_start_i;
				ack_bit   <= ctrl_ack_en_i;
				stop_bit  <= recover_wr ? 1'b0 : ctrl_stop_i;
			end
			// a new event beats a simultaneous clear
			if (ev_set) begin
				done <= 1'b1;
			end else if (ctrl_write_i & ctrl_done_clr_i) begin
				done <= 1'b0;
			end
			if (illegal_cond) begin
				status_code <= ST_BUS_ERROR;
			end else if (arb_lost & ~lost_in_addr) begin
				status_code <= ST_ARB_LOST;
			end else if (addr_done & addr_match) begin
				status_code <= sda_s ? ST_ARB_ADDR_RD : ST_ARB_ADDR_WR;
			end
		end
	end

	// ==================================================================
	// outputs
	// oe is combinational so a lost master lets go the same cycle
	wire drive_ok = (state == ACK_ENABLE_BIT_MASTER) & ~arb_lost & ~illegal_cond;
	assign sda_oe_o             = drive_ok & master_tx_en_i & ~master_tx_bit_i;
	assign scl_oe_o             = drive_ok & master_scl_low_i;
	assign bus_status_o         = done ? status_code : ST_NO_INFO;
	assign transfer_done_flag_o = done;
	assign start_request_bit_o  = start_bit;
	assign stop_request_bit_o   = stop_bit;
	assign ack_enable_bit_o     = ack_bit;
	assign mode_o               = state;
	assign start_when_free_o    = (state == ACK_ENABLE_BIT_WAIT_FREE) & ~bus_busy_o;

endmodule : ack_enable_bit_core

// *** ack_enable_bit_chk.sv ***
/* assertions on the ack_enable_bit_core ports.
   assumes the bus stays quiet while clk_en_i is low; bound below. */
`timescale 1ns/1ps
module ack_enable_bit_chk
	import ack_enable_bit_pkg::*;
(
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	input wire logic       ctrl_write_i,
	input wire logic       ctrl_stop_i,
	input wire logic       ctrl_done_clr_i,
	input wire logic       scl_oe_o,
	input wire logic       sda_oe_o,
	input wire logic       stop_request_bit_o,
	input wire logic       transfer_done_flag_o,
	input wire logic [7:0] bus_status_o,
	input wire logic [2:0] mode_o,
	input wire logic       start_when_free_o
);
	// ==========
	// properties
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	wire logic fix_w = mode_o == 3'h6 && ctrl_write_i && ctrl_stop_i && ctrl_done_clr_i;
	wire logic rise_w = transfer_done_flag_o && bus_status_o != ST_NO_INFO;

	no_info_a: assert property (!transfer_done_flag_o |-> bus_status_o == ST_NO_INFO)
		else $error("idle code missing");
	err_code_a: assert property ($rose(mode_o == 3'h6) |-> bus_status_o == 8'h00 && transfer_done_flag_o)
		else $error("bus error not flagged");
	err_release_a: assert property (mode_o == 3'h6 |-> !sda_oe_o && !scl_oe_o)
		else $error("bus held in error");
	recover_a: assert property (fix_w |=> mode_o == 3'h0 && !stop_request_bit_o && !transfer_done_flag_o)
		else $error("recovery incomplete");
	idle_again_a: assert property (fix_w |=> bus_status_o == ST_NO_INFO ##1 bus_status_o == ST_NO_INFO)
		else $error("status not idle after recovery");
	lost_release_a: assert property ($rose(rise_w) && bus_status_o == ST_ARB_LOST |-> !sda_oe_o && !scl_oe_o)
		else $error("driving after loss");
	addr_rd_a: assert property ($rose(rise_w) && bus_status_o == ST_ARB_ADDR_RD |-> mode_o == 3'h4)
		else $error("not in slave send");
	addr_wr_a: assert property ($rose(rise_w) && bus_status_o == ST_ARB_ADDR_WR |-> mode_o == 3'h3)
		else $error("not in slave receive");
	wait_free_a: assert property (start_when_free_o |-> mode_o == 3'h5 ##1 mode_o == 3'h0)
		else $error("free bus pulse misplaced");

	cover property ($rose(mode_o == 3'h6));
	cover property (fix_w);
	cover property (start_when_free_o);
endmodule : ack_enable_bit_chk

bind ack_enable_bit_core ack_enable_bit_chk i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .ctrl_write_i(ctrl_write_i),
	.ctrl_stop_i(ctrl_stop_i), .ctrl_done_clr_i(ctrl_done_clr_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
	.stop_request_bit_o(stop_request_bit_o), .transfer_done_flag_o(transfer_done_flag_o),
	.bus_status_o(bus_status_o), .mode_o(mode_o), .start_when_free_o(start_when_free_o));

// *** ack_enable_bit_peer.sv ***
/* behavioural second master on the two-wire bus, open drain.
   assumes pull-ups on both wires; its clock only moves inside frames. */
`timescale 1ns/1ps
module ack_enable_bit_peer (
	input  wire logic clock_i,
	output logic      scl_oe_o,
	output logic      sda_oe_o
);
	// ==========
	// bus phases of 80 ns
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end

	task automatic w();
		repeat (4) @(posedge clock_i);
	endtask : w

	// also a repeated start: ownership carries across it
	task automatic start_c();
		sda_oe_o <= 1'b0;
		w();
		scl_oe_o <= 1'b0;
		w();
		sda_oe_o <= 1'b1;
		w();
		scl_oe_o <= 1'b1;
		w();
	endtask : start_c

	task automatic bit_c(input logic b);
		sda_oe_o <= !b;
		w();
		scl_oe_o <= 1'b0;
		w();
		scl_oe_o <= 1'b1;
	endtask : bit_c

	task automatic stop_c();
		sda_oe_o <= 1'b1;
		w();
		scl_oe_o <= 1'b0;
		w();
		sda_oe_o <= 1'b0;
		w();
	endtask : stop_c
endmodule : ack_enable_bit_peer

// *** ack_enable_bit_core_tb.sv ***
/* self-checking bench for ack_enable_bit_core against a second bus master.
   assumes ack_enable_bit_peer and ack_enable_bit_chk are compiled before it. */
`timescale 1ns/1ps
module ack_enable_bit_core_tb;
	import ack_enable_bit_pkg::*;
	logic        clock_i, rst_n_i, wr, c_sta, c_sto, c_clr, c_ack, own_m, tx_en, tx_bit, scl_low, done_q, clk_en;
	logic [6:0]  own;
	logic [15:0] rnd;
	logic [10:0] exp_q[$];
	wire logic   d_scl, d_sda, p_scl, p_sda, sta_b, sto_b, ack_b, done, swf, busy;
	wire logic [7:0] status;
	wire logic [2:0] mode;
	wire logic   scl = !(d_scl | p_scl);
	wire logic   sda = !(d_sda | p_sda);
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          n_free = 0;

	ack_enable_bit_core i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .scl_i(scl), .sda_i(sda),
		.scl_oe_o(d_scl), .sda_oe_o(d_sda), .ctrl_write_i(wr), .ctrl_start_i(c_sta), .ctrl_stop_i(c_sto),
		.ctrl_done_clr_i(c_clr), .ctrl_ack_en_i(c_ack), .own_addr_i(own), .master_own_i(own_m),
		.master_tx_en_i(tx_en), .master_tx_bit_i(tx_bit), .master_scl_low_i(scl_low),
		.start_request_bit_o(sta_b), .stop_request_bit_o(sto_b), .ack_enable_bit_o(ack_b),
		.transfer_done_flag_o(done), .bus_status_o(status), .mode_o(mode), .bus_busy_o(busy),
		.start_when_free_o(swf));
	ack_enable_bit_peer i_peer (.clock_i(clock_i), .scl_oe_o(p_scl), .sda_oe_o(p_sda));

	// ==========
	// helpers
	function automatic logic [15:0] xs(input logic [15:0] x);
		x ^= x << 7;
		x ^= x >> 9;
		x ^= x << 8;
		return x;
	endfunction : xs

	task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic complete_run();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run

	task automatic wctl(input logic s, input logic p, input logic c, input logic a);
		@(posedge clock_i);
		wr <= 1'b1;
		c_sta <= s;
		c_sto <= p;
		c_clr <= c;
		c_ack <= a;
		@(posedge clock_i);
		wr <= 1'b0;
		#1;
	endtask : wctl

	// drop lets the core give up mastership once it has lost
	task automatic xbyte(input logic [7:0] p, input logic [7:0] d, input logic drop);
		tx_en <= 1'b1;
		for (int i = 7; i >= 0; i--) begin
			tx_bit <= d[i];
			i_peer.bit_c(p[i]);
			if (drop) begin
				own_m <= 1'b0;
			end
		end
		tx_en <= 1'b0;
		i_peer.bit_c(1'b1);
	endtask : xbyte

	task automatic settle();
		repeat (8) @(posedge clock_i);
		#1;
	endtask : settle

	// ==========
	// clock, monitor, watchdog
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	always @(posedge clock_i) begin
		scl_low <= p_scl;
		done_q <= done;
		if (swf) begin
			n_free <= n_free + 1;
		end
		if (done && !done_q) begin
			chk("flag event", {status, mode}, exp_q.size() > 0 ? exp_q.pop_front() : 11'h7ff);
		end
	end

	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end

	// ==========
	// scenarios
	initial begin
		{rst_n_i, wr, c_sta, c_sto, c_clr, c_ack, own_m, tx_en} = '0;
		tx_bit = 1'b1;
		clk_en = 1'b1;
		rnd = 16'hdcc4;
		rnd = xs(rnd);
		own = rnd[6:0] & 7'h3f;
		repeat (5) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		#1;
		chk("idle", {status, mode}, {ST_NO_INFO, 3'h0});
		// enable low: a full control write must leave nothing behind
		clk_en <= 1'b0;
		wctl(1'b1, 1'b1, 1'b0, 1'b1);
		chk("frozen", {status, sta_b, sto_b, ack_b}, {ST_NO_INFO, 3'b000});
		clk_en <= 1'b1;
		wctl(1'b0, 1'b0, 1'b0, 1'b0);
		own_m <= 1'b1;
		i_peer.start_c();
		xbyte({own, 1'b0}, 8'hff, 1'b1);
		i_peer.stop_c();
		settle();
		chk("ignored address", {status, mode}, {ST_NO_INFO, 3'h0});
		rnd = xs(xs(rnd));
		wctl(1'b1, 1'b0, 1'b0, 1'b1);
		own_m <= 1'b1;
		exp_q.push_back({ST_ARB_LOST, 3'h5});
		i_peer.start_c();
		xbyte({rnd[6:0], 1'b0}, {rnd[6:0], 1'b0}, 1'b0);
		i_peer.start_c();
		#1;
		chk("repeated start", {status, mode}, {ST_NO_INFO, 3'h1});
		chk("busy", {10'h000, busy}, 11'h001);
		xbyte({rnd[6:0], 1'b1}, {rnd[6:0], 1'b1}, 1'b0);
		xbyte(rnd[15:8] & 8'h7f, 8'hff, 1'b1);
		i_peer.stop_c();
		settle();
		chk("free bus", {status, mode}, {ST_ARB_LOST, 3'h0});
		chk("busy", {10'h000, busy}, 11'h000);
		chk("free pulses", 11'(n_free), 11'h001);
		wctl(1'b0, 1'b0, 1'b1, 1'b1);
		rnd = xs(rnd);
		own_m <= 1'b1;
		exp_q.push_back({rnd[0] ? ST_ARB_ADDR_RD : ST_ARB_ADDR_WR, rnd[0] ? 3'h4 : 3'h3});
		i_peer.start_c();
		xbyte({own, rnd[0]}, 8'hff, 1'b1);
		wctl(1'b0, 1'b0, 1'b1, 1'b1);
		exp_q.push_back({8'h00, 3'h6});
		i_peer.bit_c(1'b1);
		i_peer.bit_c(1'b0);
		i_peer.start_c();
		rnd = xs(rnd);
		wctl(rnd[0], 1'b1, 1'b1, 1'b1);
		chk("recovered", {status, mode}, {ST_NO_INFO, 3'h0});
		chk("control", {7'h00, sta_b, sto_b, ack_b, done}, {7'h00, rnd[0], 3'b010});
		chk("released", {9'h000, d_sda, d_scl}, 11'h000);
		i_peer.stop_c();
		settle();
		chk("pending", 11'(exp_q.size()), 11'h000);
		complete_run();
	end
endmodule : ack_enable_bit_core_tb
